/* rtl/sbc_codec.sv */
// Overview of operation
// - Serial bits leave in order a b c d e i f g h j.
// - Primitive characters leave in arrival order, distinguishing one first.
// - Frame characters leave in arrival order, delimiter to delimiter.
// - One shared encode function both generates and checks characters.
// - Each byte has a code for negative and for positive disparity.
// - Transmit disparity starts at a fixed value after reset.
// - Transmit disparity updates from each character sent.
// - Receive disparity starts at a fixed value after reset.
// - Every received character is checked and updates receive disparity.
// - Six-bit sub-block is abcdei, four-bit sub-block is fghj.
// - Disparity chains: previous character, six-bit, then four-bit.
// - More ones gives positive, more zeros gives negative.
// - 000111 and 0011 end positive; 111000 and 1100 end negative.
// - Other balanced sub-blocks keep the starting disparity.
// - Forced patterns emitted only from the matching starting disparity.
// - Data bytes encode per table, 00h to 100111 0100 or 011000 1011.
// - Low five byte bits select xx, high three select y.
// - Byte bit 0 is A; a separate flag marks control bytes.
// - Only listed control characters are generated or accepted.
// - Transmit and receive disparity are separate registers.
`timescale 1ns/1ps

module sbc_fifo
    import sbc_pkg::*;
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic ready_ff, nxt_ready;
    logic push, pop;

    // ****************************************
    // Pointers and honest flags
    // ****************************************
    always_comb begin
        push = in_valid && ready_ff;
        pop = out_valid && out_ready;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        if (push) begin
            nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
        // Registered ready keeps the source path short
        nxt_ready = (nxt_cnt != CW'(DEPTH));
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            ready_ff <= 1'b0;
        end else if (ce) begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    assign in_ready = ready_ff;
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
endmodule : sbc_fifo

module sbc_codec
    import sbc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire sbc_byte_type tx_in,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    output logic tx_bit,
    output logic tx_bit_valid,
    output logic tx_rd,
    input wire logic [CHAR_W-1:0] rx_char,
    input wire logic rx_char_valid,
    output sbc_dec_type rx_out,
    output logic rx_out_valid,
    output logic rx_rd
);

    // ****************************************
    // Disparity of one sub-block
    // ****************************************
    function automatic logic sub_rd6(input logic [5:0] s, input logic rd);
        logic [2:0] ones;
        ones = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]) + 3'(s[4])
            + 3'(s[5]);
        if (ones > 3'd3) begin
            return RD_POS;
        end else if (ones < 3'd3) begin
            return RD_NEG;
        end else if (s == SUB6_FORCE_POS) begin
            return RD_POS;
        end else if (s == SUB6_FORCE_NEG) begin
            return RD_NEG;
        end else begin
            return rd;
        end
    endfunction : sub_rd6

    function automatic logic sub_rd4(input logic [3:0] s, input logic rd);
        logic [2:0] ones;
        ones = 3'(s[0]) + 3'(s[1]) + 3'(s[2]) + 3'(s[3]);
        if (ones > 3'd2) begin
            return RD_POS;
        end else if (ones < 3'd2) begin
            return RD_NEG;
        end else if (s == SUB4_FORCE_POS) begin
            return RD_POS;
        end else if (s == SUB4_FORCE_NEG) begin
            return RD_NEG;
        end else begin
            return rd;
        end
    endfunction : sub_rd4

    // Six-bit result feeds the four-bit start
    function automatic logic char_rd(input logic [CHAR_W-1:0] c,
                                     input logic rd);
        logic r6;
        r6 = sub_rd6(c[SUB6_HI:SUB6_LO], rd);
        return sub_rd4(c[SUB4_HI:SUB4_LO], r6);
    endfunction : char_rd

    // ****************************************
    // Control character check
    // ****************************************
    function automatic logic k_ok(input logic [BYTE_W-1:0] b);
        logic [4:0] x;
        x = b[4:0];
        return (x == X_K28) || ((b[7:5] == Y_ALT) && ((x == X_K23)
            || (x == X_K27) || (x == X_K29) || (x == X_K30)));
    endfunction : k_ok

    // ****************************************
    // Encoder shared by both directions
    // ****************************************
    function automatic logic [CHAR_W-1:0] enc(input logic [BYTE_W-1:0] b,
                                             input logic k,
                                             input logic rd);
        logic [4:0] x;
        logic [2:0] y;
        logic [5:0] c6;
        logic [3:0] c4;
        logic r6;
        logic alt;
        logic bal4;
        logic inv4;
        x = b[4:0];
        y = b[7:5];
        c6 = (k && x == X_K28) ? K28_6B : TBL6[x];
        // At positive disparity, complement if more ones, or if 000111 or 111000
        if (rd == RD_POS
            && (sub_rd6(c6, RD_NEG) != RD_NEG || c6 == SUB6_FORCE_NEG)) begin
            c6 = ~c6;
        end
        r6 = sub_rd6(c6, rd);
        // Alternate form keeps run length at five
        alt = (y == Y_ALT) && (k
            || (r6 == RD_NEG && (x == 5'h11 || x == 5'h12 || x == 5'h14))
            || (r6 == RD_POS && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
        c4 = alt ? ALT4 : TBL4[y];
        bal4 = (sub_rd4(c4, RD_NEG) == RD_POS) && (c4 != SUB4_FORCE_POS)
            ? 1'b0 : (sub_rd4(c4, RD_POS) == RD_NEG && c4 != SUB4_FORCE_NEG)
            ? 1'b0 : 1'b1;
        if (!bal4 || c4 == SUB4_FORCE_NEG) begin
            inv4 = (r6 == RD_POS);
        end else begin
            inv4 = k && (r6 == RD_NEG);
        end
        if (inv4) begin
            c4 = ~c4;
        end
        return {c6, c4};
    endfunction : enc

    // ****************************************
    // Transmit path: buffer, encoder, shifter
    // ****************************************
    sbc_byte_type q_data;
    logic q_valid;
    logic q_ready;
    logic [CHAR_W-2:0] sh_ff, nxt_sh;
    logic [3:0] left_ff, nxt_left;
    logic bit_ff, nxt_bit;
    logic bitv_ff, nxt_bitv;
    logic trd_ff, nxt_trd;
    logic [CHAR_W-1:0] tx_code;

    // Strict FIFO order keeps primitives and frames intact
    sbc_fifo #(
        .WIDTH($bits(sbc_byte_type)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .in_data(tx_in),
        .in_valid(tx_in_valid),
        .in_ready(tx_in_ready),
        .out_data(q_data),
        .out_valid(q_valid),
        .out_ready(q_ready)
    );

    always_comb begin
        tx_code = enc(q_data.data, q_data.k, trd_ff);
        // Shifter busy stalls the buffer drain
        q_ready = (left_ff == 4'h0);
        nxt_sh = sh_ff;
        nxt_left = left_ff;
        nxt_bit = bit_ff;
        nxt_bitv = 1'b0;
        nxt_trd = trd_ff;
        if (left_ff != 4'h0) begin
            nxt_bit = sh_ff[CHAR_W-2];
            nxt_sh = {sh_ff[CHAR_W-3:0], 1'b0};
            nxt_left = left_ff - 4'h1;
            nxt_bitv = 1'b1;
        end else if (q_valid) begin
            // Illegal control bytes are dropped, never sent
            if (!q_data.k || k_ok(q_data.data)) begin
                nxt_bit = tx_code[CHAR_W-1];
                nxt_sh = tx_code[CHAR_W-2:0];
                nxt_left = 4'(CHAR_W - 1);
                nxt_bitv = 1'b1;
                nxt_trd = char_rd(tx_code, trd_ff);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sh_ff <= '0;
            left_ff <= 4'h0;
            bit_ff <= 1'b0;
            bitv_ff <= 1'b0;
            trd_ff <= RD_RESET;
        end else if (ce) begin
            sh_ff <= nxt_sh;
            left_ff <= nxt_left;
            bit_ff <= nxt_bit;
            bitv_ff <= nxt_bitv;
            trd_ff <= nxt_trd;
        end
    end

    // ****************************************
    // Receive path: decode and check
    // ****************************************
    sbc_dec_type dec_ff, nxt_dec;
    logic decv_ff, nxt_decv;
    logic rrd_ff, nxt_rrd;
    logic [BYTE_W:0] cand;

    always_comb begin
        nxt_dec = dec_ff;
        nxt_decv = 1'b0;
        nxt_rrd = rrd_ff;
        cand = '0;
        if (rx_char_valid) begin
            nxt_dec = '{err: 1'b1, k: 1'b0, data: '0};
            // Exhaustive match against the encoder's own output
            for (int i = 0; i < 512; i++) begin
                cand = (BYTE_W + 1)'(i);
                if ((!cand[BYTE_W] || k_ok(cand[BYTE_W-1:0])) &&
                    enc(cand[BYTE_W-1:0], cand[BYTE_W], rrd_ff) == rx_char)
                begin
                    nxt_dec = '{err: 1'b0, k: cand[BYTE_W],
                                data: cand[BYTE_W-1:0]};
                end
            end
            nxt_decv = 1'b1;
            nxt_rrd = char_rd(rx_char, rrd_ff);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dec_ff <= '0;
            decv_ff <= 1'b0;
            rrd_ff <= RD_RESET;
        end else if (ce) begin
            dec_ff <= nxt_dec;
            decv_ff <= nxt_decv;
            rrd_ff <= nxt_rrd;
        end
    end

    assign tx_bit = bit_ff;
    assign tx_bit_valid = bitv_ff;
    assign tx_rd = trd_ff;
    assign rx_out = dec_ff;
    assign rx_out_valid = decv_ff;
    assign rx_rd = rrd_ff;
endmodule : sbc_codec

/* rtl/sbc_pkg.sv */
package sbc_pkg;

    // ****************************************
    // Widths and disparity values
    // ****************************************
    localparam int BYTE_W = 8;
    localparam int CHAR_W = 10;
    localparam int FIFO_DEPTH = 4;
    localparam logic RD_NEG = 1'b0;
    localparam logic RD_POS = 1'b1;
    localparam logic RD_RESET = RD_NEG;

    // ****************************************
    // Sub-block field positions (a at msb)
    // ****************************************
    localparam int SUB6_HI = 9;
    localparam int SUB6_LO = 4;
    localparam int SUB4_HI = 3;
    localparam int SUB4_LO = 0;

    // ****************************************
    // Balanced patterns that force disparity
    // ****************************************
    localparam logic [5:0] SUB6_FORCE_POS = 6'h07;
    localparam logic [5:0] SUB6_FORCE_NEG = 6'h38;
    localparam logic [3:0] SUB4_FORCE_POS = 4'h3;
    localparam logic [3:0] SUB4_FORCE_NEG = 4'hC;

    // ****************************************
    // Code tables, negative running disparity
    // ****************************************
    localparam logic [5:0] TBL6 [32] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
    localparam logic [3:0] TBL4 [8] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
    localparam logic [3:0] ALT4 = 4'h7;
    localparam logic [5:0] K28_6B = 6'h0F;

    // ****************************************
    // Code groups with special handling
    // ****************************************
    localparam logic [4:0] X_K28 = 5'h1C;
    localparam logic [4:0] X_K23 = 5'h17;
    localparam logic [4:0] X_K27 = 5'h1B;
    localparam logic [4:0] X_K29 = 5'h1D;
    localparam logic [4:0] X_K30 = 5'h1E;
    localparam logic [2:0] Y_ALT = 3'h7;

    typedef struct packed {
        logic k;
        logic [BYTE_W-1:0] data;
    } sbc_byte_type;

    typedef struct packed {
        logic err;
        logic k;
        logic [BYTE_W-1:0] data;
    } sbc_dec_type;

endpackage : sbc_pkg

/* tb/sbc_codec_asserts.sv */
`timescale 1ns/1ps

module sbc_codec_asserts
    import sbc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    input wire sbc_byte_type tx_in,
    input wire logic tx_in_valid,
    input wire logic tx_in_ready,
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    input wire logic tx_rd,
    input wire logic [CHAR_W-1:0] rx_char,
    input wire logic rx_char_valid,
    input wire sbc_dec_type rx_out,
    input wire logic rx_out_valid,
    input wire logic rx_rd
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic take;
    assign take = rx_char_valid && ce;

    // ****************************************
    // Receive side
    // ****************************************
    property p_rx_lat;
        take |=> rx_out_valid;
    endproperty
    a_rx_lat: assert property (p_rx_lat)
        else $error("rx result missing one cycle after char");
    property p_rx_idle;
        !take |=> (!rx_out_valid || !$past(ce)) && $stable(rx_rd)
            && $stable(rx_out);
    endproperty
    a_rx_idle: assert property (p_rx_idle)
        else $error("rx state moved without a char");
    property p_err_zero;
        rx_out_valid && rx_out.err |-> !rx_out.k && rx_out.data == 8'h00;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("invalid char result not cleared");
    // Final disparity is fixed by the four-bit sub-block in these cases
    property p_sub4_pos;
        take && ($countones(rx_char[3:0]) > 2 || rx_char[3:0] == 4'h3)
            |=> rx_rd;
    endproperty
    a_sub4_pos: assert property (p_sub4_pos)
        else $error("rx disparity not positive");
    property p_sub4_neg;
        take && ($countones(rx_char[3:0]) < 2 || rx_char[3:0] == 4'hC)
            |=> !rx_rd;
    endproperty
    a_sub4_neg: assert property (p_sub4_neg)
        else $error("rx disparity not negative");
    property p_d00;
        take && !rx_rd && rx_char == 10'h274 |=> rx_out == 10'h000;
    endproperty
    a_d00: assert property (p_d00)
        else $error("zero byte decode wrong");

    // ****************************************
    // Transmit side
    // ****************************************
    property p_tx_burst;
        $rose(tx_bit_valid) |-> tx_bit_valid [*8] ##1 tx_bit_valid [*2];
    endproperty
    a_tx_burst: assert property (p_tx_burst)
        else $error("character burst shorter than ten bits");
    property p_txrd_idle;
        !tx_bit_valid ##1 !tx_bit_valid |-> $stable(tx_rd);
    endproperty
    a_txrd_idle: assert property (p_txrd_idle)
        else $error("tx disparity moved while idle");

    c_rx_err: cover property (rx_out_valid && rx_out.err);
    c_tx_burst: cover property ($rose(tx_bit_valid));
    c_full: cover property (tx_in_valid && !tx_in_ready);
    c_freeze: cover property (!ce && rx_char_valid);
endmodule : sbc_codec_asserts

bind sbc_codec sbc_codec_asserts #(.DEPTH(DEPTH)) u_sbc_codec_asserts (
    .clock(clock), .rst_b(rst_b), .ce(ce), .tx_in(tx_in),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_rd(tx_rd),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_out(rx_out),
    .rx_out_valid(rx_out_valid), .rx_rd(rx_rd));

/* tb/sbc_codec_tb_top.sv */
`timescale 1ns/1ps

module sbc_codec_tb_top
    import sbc_pkg::*;
;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    sbc_byte_type tx_in = '0;
    logic tx_in_valid = 1'b0;
    logic tx_in_ready, tx_bit, tx_bit_valid, tx_rd;
    logic [CHAR_W-1:0] rx_char = '0;
    logic rx_char_valid = 1'b0;
    sbc_dec_type rx_out;
    logic rx_out_valid, rx_rd;
    logic [CHAR_W-1:0] line_char;
    logic line_stb;
    logic [CHAR_W-1:0] got_q [$];
    int failures = 0;
    int compares = 0;

    always #2.5 clock = ~clock;

    sbc_codec u_sbc_codec (.clock(clock), .rst_b(rst_b), .ce(ce),
        .tx_in(tx_in), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_rd(tx_rd),
        .rx_char(rx_char), .rx_char_valid(rx_char_valid), .rx_out(rx_out),
        .rx_out_valid(rx_out_valid), .rx_rd(rx_rd));
    sbc_line_model u_sbc_line_model (.clock(clock), .rst_b(rst_b),
        .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
        .char_ff(line_char), .char_stb_ff(line_stb));

    always @(posedge clock) begin
        if (line_stb === 1'b1) begin
            got_q.push_back(line_char);
        end
    end

    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic chk(input logic [CHAR_W-1:0] seen,
                       input logic [CHAR_W-1:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t mismatch seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run;
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // ****************************************
    // Scenarios
    // ****************************************
    // Mixed stream with a dropped control byte, overfills the FIFO
    task automatic t_tx_stream;
        sbc_byte_type bytes [7] = '{9'h000, 9'h007, 9'h100, 9'h000,
                                   9'h007, 9'h003, 9'h1BC};
        logic [CHAR_W-1:0] exp [6] = '{10'h274, 10'h38B, 10'h18B,
                                      10'h074, 10'h31B, 10'h305};
        logic saw_full;
        int n;
        saw_full = 1'b0;
        for (int i = 0; i < 7; i++) begin
            tx_in <= bytes[i];
            tx_in_valid <= 1'b1;
            @(posedge clock);
            while (tx_in_ready !== 1'b1) begin
                saw_full = 1'b1;
                @(posedge clock);
            end
        end
        tx_in_valid <= 1'b0;
        n = 0;
        while (got_q.size() < 6 && n < 200) begin
            @(posedge clock);
            n++;
        end
        repeat (20) @(posedge clock);
        chk(CHAR_W'(got_q.size()), 10'h006);
        for (int i = 0; i < 6; i++) begin
            chk(got_q[i], exp[i]);
        end
        chk(CHAR_W'(tx_rd), 10'h000);
        chk(CHAR_W'(saw_full), 10'h001);
    endtask : t_tx_stream

    // Back-to-back decode, then a bad char and a wrong-disparity char
    task automatic t_rx_table;
        logic [CHAR_W-1:0] ch [8] = '{10'h274, 10'h38B, 10'h18B, 10'h074,
                                     10'h31B, 10'h305, 10'h000, 10'h18B};
        logic [CHAR_W-1:0] res [8] = '{10'h000, 10'h007, 10'h000, 10'h007,
                                      10'h003, 10'h1BC, 10'h200, 10'h200};
        logic rd [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i <= 8; i++) begin
            @(posedge clock);
            rx_char <= (i < 8) ? ch[i] : 10'h000;
            rx_char_valid <= (i < 8);
            if (i > 0) begin
                #1;
                chk(rx_out, res[i-1]);
                chk(CHAR_W'(rx_rd), CHAR_W'(rd[i-1]));
                chk(CHAR_W'(rx_out_valid), 10'h001);
            end
        end
        @(posedge clock);
        #1;
        chk(CHAR_W'(tx_rd), 10'h000);
    endtask : t_rx_table

    // Mid-run reset returns receive disparity to its start value
    task automatic t_reset_again;
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(CHAR_W'(rx_rd), 10'h000);
        chk(CHAR_W'(tx_bit_valid), 10'h000);
        @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
    endtask : t_reset_again

    // Clock enable low must freeze the receive path, char held pending
    task automatic t_ce_freeze;
        @(posedge clock);
        ce <= 1'b0;
        rx_char <= 10'h18B;
        rx_char_valid <= 1'b1;
        repeat (3) @(posedge clock);
        #1;
        chk(CHAR_W'(rx_out_valid), 10'h000);
        chk(rx_out, 10'h200);
        chk(CHAR_W'(rx_rd), 10'h001);
        @(posedge clock);
        ce <= 1'b1;
        @(posedge clock);
        rx_char_valid <= 1'b0;
        #1;
        chk(rx_out, 10'h000);
        chk(CHAR_W'(rx_out_valid), 10'h001);
        chk(CHAR_W'(rx_rd), 10'h001);
        @(posedge clock);
    endtask : t_ce_freeze

    initial begin
        repeat (5) @(posedge clock);
        #1;
        chk(CHAR_W'({tx_rd, rx_rd}), 10'h000);
        @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        t_tx_stream();
        t_rx_table();
        t_reset_again();
        t_rx_table();
        t_ce_freeze();
        complete_run();
    end

    // Generous bound, the full run needs well under a thousand cycles
    initial begin
        #(20000 * 5);
        failures++;
        complete_run();
    end
endmodule : sbc_codec_tb_top

/* tb/sbc_line_model.sv */
`timescale 1ns/1ps

module sbc_line_model
    import sbc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic tx_bit,
    input wire logic tx_bit_valid,
    output logic [CHAR_W-1:0] char_ff,
    output logic char_stb_ff
);
    logic [8:0] sh_ff;
    logic [3:0] cnt_ff;

    // ****************************************
    // Deserializer, bit a lands at msb
    // ****************************************
    // No back-pressure: the far side can never stall the line
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sh_ff <= '0;
            cnt_ff <= '0;
            char_ff <= '0;
            char_stb_ff <= 1'b0;
        end else begin
            char_stb_ff <= 1'b0;
            if (tx_bit_valid) begin
                sh_ff <= {sh_ff[7:0], tx_bit};
                cnt_ff <= (cnt_ff == 4'h9) ? 4'h0 : cnt_ff + 4'h1;
                if (cnt_ff == 4'h9) begin
                    char_ff <= {sh_ff, tx_bit};
                    char_stb_ff <= 1'b1;
                end
            end
        end
    end
endmodule : sbc_line_model
